//--- hdl/cpc_top.sv
// Function
// - command byte at 0x860 upper lane
// - software sets semaphore, device clears when done
// - reset bit requests reset, device clears it
// - special select reinterprets opcode as interface command
// - opcode and channel decode to strobes
// - one shared command, mask, mode set
// - 16-bit interface mode register at 0x8b4
// - mode bit 15 forces transmit data zero when interface select is special
// - mode bit 14 selects sync pulse shape
// - diagnostic field decodes four modes
`timescale 1ns/1ps
module cpc_top (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [cpc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [cpc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // channel status in
    input cpc_pkg::cpc_lstat_t chan_line_status,
    // layer-1 transmit path
    input wire logic layer1_tx_in,
    output logic layer1_tx_data,
    // serial interface configuration out
    output cpc_pkg::cpc_if_cfg_t if_cfg,
    // command results
    output cpc_pkg::cpc_chan_cmd_t chan_cmd,
    output cpc_pkg::cpc_special_t special_cmd,
    output logic soft_reset,
    output logic cmd_busy
);
    import cpc_pkg::*;

    // all state of the register slave
    typedef struct packed {
        logic aw_held;
        logic [AXI_AW-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rpend;
        logic [AXI_AW-1:0] ar_addr;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        cpc_cmd_t cmd;
        logic start;
        logic [15:0] mask;
        logic [15:0] mode;
        logic l1;
    } cpc_top_st_t;

    localparam cpc_top_st_t ST_RST = '{
        cmd: cpc_cmd_t'(CMD_RST_VAL),
        mask: MASK_RST_VAL,
        mode: MODE_RST_VAL,
        default: '0
    };

    cpc_top_st_t s_q, s_d;

    // byte address to register kind, channel and offset
    function automatic cpc_adec_t addr_decode(
        input logic [AXI_AW-1:0] a
    );
        cpc_adec_t r;
        logic [11:0] idx;
        logic [11:0] rel;
        idx = a[AXI_AW-1:2];
        rel = idx - CHAN_BASE_IDX;
        r.kind = AK_NONE;
        r.ch = rel[5:4];
        r.sub = rel[3:0];
        if (idx == CMD_IDX) begin
            r.kind = AK_CMD;
        end else if (idx == MASK_IDX) begin
            r.kind = AK_MASK;
        end else if (idx == MODE_IDX) begin
            r.kind = AK_MODE;
        end else if (idx >= CHAN_BASE_IDX && rel < CHAN_SPAN) begin
            // per-channel set, offset picks the register
            if (r.sub == CH_LSTAT_OFS) begin
                r.kind = AK_LSTAT;
            end else if (r.sub == CH_CFG_OFS || r.sub == CH_PMODE_OFS ||
                         r.sub == CH_SYNC_OFS || r.sub == CH_EVT_OFS ||
                         r.sub == CH_EVM_OFS) begin
                r.kind = AK_CHAN;
            end
        end
        return r;
    endfunction

    // channel register word address
    function automatic logic [4:0] mem_addr(input cpc_adec_t d);
        return {d.ch, d.sub[3:1]};
    endfunction

    // merge a 16-bit register with two byte lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] nw,
        input logic [1:0] be
    );
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = nw[7:0];
        end
        if (be[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    // decodes of pending write and read
    cpc_adec_t wdec;
    cpc_adec_t rdec;
    cpc_adec_t ardec;
    // write ready to perform
    logic do_write;
    // channel memory port
    logic mem_we;
    logic mem_re;
    logic [15:0] mem_rdata;
    // executor completion
    logic ex_done;
    // incoming command byte
    cpc_cmd_t wcmd;

    assign wdec = addr_decode(s_q.aw_addr);
    assign rdec = addr_decode(s_q.ar_addr);
    assign ardec = addr_decode(s_axi_araddr);
    assign wcmd = cpc_cmd_t'(s_q.w_data[CMD_LANE_LSB +: 8] & CMD_KEEP_MASK);

    // handshake readies, frozen with the clock enable
    assign s_axi_awready = ce && !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = ce && !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready = ce && !s_q.rpend && !s_q.rvalid;
    assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign mem_we = ce && do_write && wdec.kind == AK_CHAN;
    assign mem_re = s_axi_arvalid && s_axi_arready;

    // next-state logic of the slave and its registers
    always_comb begin
        s_d = s_q;
        if (ce) begin
            s_d.start = 1'b0;
            // address and data captured in either order
            if (s_axi_awvalid && s_axi_awready) begin
                s_d.aw_held = 1'b1;
                s_d.aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_d.w_held = 1'b1;
                s_d.w_data = s_axi_wdata;
                s_d.w_strb = s_axi_wstrb;
            end
            if (s_q.bvalid && s_axi_bready) begin
                s_d.bvalid = 1'b0;
            end
            // perform a write once both halves are in
            if (do_write) begin
                s_d.aw_held = 1'b0;
                s_d.w_held = 1'b0;
                s_d.bvalid = 1'b1;
                s_d.bresp = RESP_OKAY;
                unique case (wdec.kind)
                    AK_CMD: begin
                        if (!s_q.cmd.command_semaphore && s_q.w_strb[1]) begin
                            s_d.cmd = wcmd;
                            s_d.start = wcmd.command_semaphore;
                        end
                    end
                    AK_MASK: begin
                        s_d.mask = merge16(s_q.mask, s_q.w_data[15:0],
                                           s_q.w_strb[1:0]);
                    end
                    AK_MODE: begin
                        s_d.mode = merge16(s_q.mode, s_q.w_data[15:0],
                                           s_q.w_strb[1:0]);
                    end
                    AK_CHAN: begin
                        // stored by the channel memory
                    end
                    AK_LSTAT: begin
                        // read-only, write ignored
                    end
                    AK_NONE: begin
                        s_d.bresp = RESP_DECERR;
                    end
                endcase
            end
            // read request, data follows next cycle
            if (mem_re) begin
                s_d.rpend = 1'b1;
                s_d.ar_addr = s_axi_araddr;
            end
            if (s_q.rvalid && s_axi_rready) begin
                s_d.rvalid = 1'b0;
            end
            if (s_q.rpend) begin
                s_d.rpend = 1'b0;
                s_d.rvalid = 1'b1;
                s_d.rresp = RESP_OKAY;
                s_d.rdata = 32'h0000_0000;
                unique case (rdec.kind)
                    AK_CMD: s_d.rdata[CMD_LANE_LSB +: 8] = s_q.cmd;
                    AK_MASK: s_d.rdata[15:0] = s_q.mask;
                    AK_MODE: s_d.rdata[15:0] = s_q.mode;
                    AK_CHAN: begin
                        // event and mask registers are 8 bits wide
                        if (rdec.sub == CH_EVT_OFS || rdec.sub == CH_EVM_OFS) begin
                            s_d.rdata[7:0] = mem_rdata[7:0];
                        end else begin
                            s_d.rdata[15:0] = mem_rdata;
                        end
                    end
                    AK_LSTAT: s_d.rdata[7:0] = chan_line_status[rdec.ch];
                    AK_NONE: s_d.rresp = RESP_DECERR;
                endcase
            end
            if (ex_done) begin
                s_d.cmd.command_semaphore = 1'b0;
                // reset bit cleared, mask and mode reinitialised
                if (s_q.cmd.rst) begin
                    s_d.cmd.rst = 1'b0;
                    s_d.mask = MASK_RST_VAL;
                    s_d.mode = MODE_RST_VAL;
                end
            end
            // force transmit zero in special mode
            s_d.l1 = layer1_tx_in && !if_cfg.force_tx_zero;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // one shared configuration from mode and mask
    always_comb begin
        if_cfg = '0;
        if_cfg.bit_mask = s_q.mask;
        if_cfg.iface_sel = s_q.mode[MODE_SEL_LSB +: 2];
        if_cfg.force_tx_zero = s_q.mode[MODE_FORCE_TX_ZERO_BIT] &&
                               if_cfg.iface_sel == IFACE_SPECIAL;
        if_cfg.sync_pulse_shape = s_q.mode[MODE_SHAPE_BIT];
        unique case (cpc_diag_t'(s_q.mode[MODE_DIAG_LSB +: 2]))
            DIAG_NORMAL: begin
                // normal operation
            end
            DIAG_ECHO: if_cfg.diag_echo = 1'b1;
            DIAG_INT_LOOP: if_cfg.diag_int_loop = 1'b1;
            DIAG_LOOP_CTRL: if_cfg.diag_loop_ctrl = 1'b1;
        endcase
    end

    // per-channel register storage
    cpc_chan_regs #(
        .W(16),
        .AW(5)
    ) u_chan_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_addr(wdec)),
        .wdata(s_q.w_data[15:0]),
        .wbe(s_q.w_strb[1:0]),
        .re(mem_re),
        .raddr(mem_addr(ardec)),
        .rdata(mem_rdata)
    );

    // command executor, reads the held command byte
    cpc_cmd_exec #(
        .EXEC_CYC(CMD_EXEC_CYC),
        .RST_CYC(RST_SEQ_CYC)
    ) u_exec (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .start(s_q.start),
        .cmd(s_q.cmd),
        .done(ex_done),
        .chan_cmd(chan_cmd),
        .special(special_cmd),
        .soft_reset(soft_reset)
    );

    // axi outputs from registers
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = s_q.rdata;
    assign layer1_tx_data = s_q.l1;
    assign cmd_busy = s_q.cmd.command_semaphore;
endmodule

//--- hdl/cpc_pkg.sv
package cpc_pkg;
    // clock rate
    localparam int CLK_MHZ = 200;
    // axi byte address width
    localparam int AXI_AW = 14;
    // register indexes, byte address is four times the index
    localparam logic [11:0] CMD_IDX = 12'h860;
    localparam logic [11:0] MASK_IDX = 12'h8b2;
    localparam logic [11:0] MODE_IDX = 12'h8b4;
    localparam logic [11:0] CHAN_BASE_IDX = 12'h880;
    localparam logic [11:0] CHAN_SPAN = 12'h030;
    // per-channel register offsets inside one channel set
    localparam logic [3:0] CH_CFG_OFS = 4'h2;
    localparam logic [3:0] CH_PMODE_OFS = 4'h4;
    localparam logic [3:0] CH_SYNC_OFS = 4'h6;
    localparam logic [3:0] CH_EVT_OFS = 4'h8;
    localparam logic [3:0] CH_EVM_OFS = 4'ha;
    localparam logic [3:0] CH_LSTAT_OFS = 4'hc;
    // command byte sits on data bits 15:8
    localparam int CMD_LANE_LSB = 8;
    localparam int CMD_RST_BIT = 7;
    localparam int CMD_SPC_BIT = 6;
    localparam int CMD_OPC_LSB = 4;
    localparam int CMD_CH_LSB = 1;
    localparam int CMD_SEM_BIT = 0;
    localparam logic [7:0] CMD_KEEP_MASK = 8'hf7;
    // reset values
    localparam logic [7:0] CMD_RST_VAL = 8'h00;
    localparam logic [15:0] MASK_RST_VAL = 16'h0000;
    localparam logic [15:0] MODE_RST_VAL = 16'h0000;
    localparam logic [15:0] CHAN_RST_VAL = 16'h0000;
    // mode register fields
    localparam int MODE_FORCE_TX_ZERO_BIT = 15;
    localparam int MODE_SHAPE_BIT = 14;
    localparam int MODE_DIAG_LSB = 12;
    localparam int MODE_SEL_LSB = 0;
    localparam logic [1:0] IFACE_SPECIAL = 2'h3;
    // channel codes
    localparam logic [1:0] CH_RESERVED = 2'h3;
    localparam logic [1:0] CH_SPECIAL = 2'h2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // command timing
    localparam int CMD_EXEC_NS = 50;
    localparam int CMD_EXEC_CYC = (CMD_EXEC_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_SEQ_NS = 100;
    localparam int RST_SEQ_CYC = (RST_SEQ_NS * CLK_MHZ + 999) / 1000;

    // command opcodes
    typedef enum logic [1:0] {
        OPC_STOP_TX = 2'h0,
        OPC_RESTART_TX = 2'h1,
        OPC_ENTER_HUNT = 2'h2,
        OPC_RESET_RX_BCS = 2'h3
    } cpc_opcode_t;

    // diagnostic modes
    typedef enum logic [1:0] {
        DIAG_NORMAL = 2'h0,
        DIAG_ECHO = 2'h1,
        DIAG_INT_LOOP = 2'h2,
        DIAG_LOOP_CTRL = 2'h3
    } cpc_diag_t;

    // processor command byte
    typedef struct packed {
        logic rst;
        logic special_iface_cmd_select;
        cpc_opcode_t opcode;
        logic rsvd;
        logic [1:0] target_channel;
        logic command_semaphore;
    } cpc_cmd_t;

    // one-cycle per-channel command strobes
    typedef struct packed {
        logic [2:0] stop_tx;
        logic [2:0] restart_tx;
        logic [2:0] enter_hunt;
        logic [2:0] reset_rx_bcs;
    } cpc_chan_cmd_t;

    // special-interface command strobe
    typedef struct packed {
        logic valid;
        cpc_opcode_t opcode;
    } cpc_special_t;

    // decoded serial interface configuration
    typedef struct packed {
        logic force_tx_zero;
        logic sync_pulse_shape;
        logic diag_echo;
        logic diag_int_loop;
        logic diag_loop_ctrl;
        logic [1:0] iface_sel;
        logic [15:0] bit_mask;
    } cpc_if_cfg_t;

    // line status of the three channels
    typedef logic [2:0][7:0] cpc_lstat_t;

    // address decode result
    typedef enum logic [2:0] {
        AK_NONE, AK_CMD, AK_MASK, AK_MODE, AK_CHAN, AK_LSTAT
    } cpc_akind_t;

    typedef struct packed {
        cpc_akind_t kind;
        logic [1:0] ch;
        logic [3:0] sub;
    } cpc_adec_t;
endpackage

//--- hdl/cpc_chan_regs.sv
`timescale 1ns/1ps
module cpc_chan_regs #(
    parameter int W = 16,
    parameter int AW = 5
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write port with byte enables
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [1:0] wbe,
    // read port, data one cycle later
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    import cpc_pkg::*;

    // whole memory state
    typedef struct packed {
        logic [(1<<AW)-1:0][W-1:0] mem;
        logic [W-1:0] rd;
    } cpc_mem_st_t;

    cpc_mem_st_t s_q, s_d;

    // next state: lane-wise write, registered read
    always_comb begin
        s_d = s_q;
        if (ce) begin
            for (int b = 0; b < 2; b++) begin
                if (we && wbe[b]) begin
                    s_d.mem[waddr][b*8 +: 8] = wdata[b*8 +: 8];
                end
            end
            if (re) begin
                s_d.rd = s_q.mem[raddr];
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '{mem: {(1<<AW){CHAN_RST_VAL}}, rd: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rd;
endmodule

//--- hdl/cpc_cmd_exec.sv
`timescale 1ns/1ps
module cpc_cmd_exec #(
    parameter int EXEC_CYC = cpc_pkg::CMD_EXEC_CYC,
    parameter int RST_CYC = cpc_pkg::RST_SEQ_CYC
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // command in
    input wire logic start,
    input cpc_pkg::cpc_cmd_t cmd,
    // results
    output logic done,
    output cpc_pkg::cpc_chan_cmd_t chan_cmd,
    output cpc_pkg::cpc_special_t special,
    output logic soft_reset
);
    import cpc_pkg::*;

    typedef enum logic [1:0] {EX_IDLE, EX_RUN, EX_RESET} cpc_ex_st_t;

    // executor state
    typedef struct packed {
        cpc_ex_st_t st;
        logic [15:0] cnt;
        logic done;
        cpc_chan_cmd_t chan;
        cpc_special_t spc;
        logic srst;
    } cpc_ex_t;

    cpc_ex_t s_q, s_d;

    // sequencing of one command
    always_comb begin
        s_d = s_q;
        if (ce) begin
            s_d.done = 1'b0;
            s_d.chan = '0;
            s_d.spc = '0;
            s_d.srst = 1'b0;
            unique case (s_q.st)
                EX_IDLE: begin
                    if (start && cmd.rst) begin
                        s_d.st = EX_RESET;
                        s_d.cnt = 16'(RST_CYC - 1);
                    end else if (start) begin
                        s_d.st = EX_RUN;
                        s_d.cnt = 16'(EXEC_CYC - 1);
                    end
                end
                EX_RUN: begin
                    if (s_q.cnt == 16'h0000) begin
                        s_d.st = EX_IDLE;
                        s_d.done = 1'b1;
                        if (cmd.special_iface_cmd_select) begin
                            s_d.spc.valid = 1'b1;
                            s_d.spc.opcode = cmd.opcode;
                        end else begin
                            for (int i = 0; i < 3; i++) begin
                                if (cmd.target_channel == 2'(i)) begin
                                    unique case (cmd.opcode)
                                        OPC_STOP_TX: s_d.chan.stop_tx[i] = 1'b1;
                                        OPC_RESTART_TX:
                                            s_d.chan.restart_tx[i] = 1'b1;
                                        OPC_ENTER_HUNT:
                                            s_d.chan.enter_hunt[i] = 1'b1;
                                        OPC_RESET_RX_BCS:
                                            s_d.chan.reset_rx_bcs[i] = 1'b1;
                                    endcase
                                end
                            end
                        end
                    end else begin
                        s_d.cnt = s_q.cnt - 16'h0001;
                    end
                end
                EX_RESET: begin
                    if (s_q.cnt == 16'h0000) begin
                        s_d.st = EX_IDLE;
                        s_d.done = 1'b1;
                        s_d.srst = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '{st: EX_IDLE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign chan_cmd = s_q.chan;
    assign special = s_q.spc;
    assign soft_reset = s_q.srst;
endmodule

//--- dv/cpc_top_asserts.sv
`timescale 1ns/1ps
module cpc_top_asserts (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // response channels
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // serial side and command results
    input wire logic layer1_tx_in,
    input wire logic layer1_tx_data,
    input cpc_pkg::cpc_if_cfg_t if_cfg,
    input cpc_pkg::cpc_chan_cmd_t chan_cmd,
    input cpc_pkg::cpc_special_t special_cmd,
    input wire logic cmd_busy
);
    import cpc_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_tx_gate: assert property ($past(aresetn) && $past(ce) |->
        layer1_tx_data == ($past(layer1_tx_in) & ~$past(if_cfg[22])))
        else $error("tx data not gated");
    a_force_gci: assert property (if_cfg.force_tx_zero |->
        if_cfg.iface_sel == IFACE_SPECIAL) else $error("force outside gci");
    a_diag_onehot: assert property ($onehot0({if_cfg.diag_echo,
        if_cfg.diag_int_loop, if_cfg.diag_loop_ctrl}))
        else $error("diag decode overlap");
    a_strobe_done: assert property (|chan_cmd || special_cmd.valid |=>
        $fell(cmd_busy)) else $error("strobe without busy fall");
    a_strobe_one: assert property ($onehot0(chan_cmd))
        else $error("several strobes");
    a_special_only: assert property (special_cmd.valid |->
        chan_cmd == '0) else $error("channel strobe on special");
    a_busy_hold: assert property ($rose(cmd_busy) |-> cmd_busy[*8])
        else $error("busy dropped early");
    a_busy_bound: assert property ($rose(cmd_busy) |-> ##[1:40]
        !cmd_busy) else $error("busy never cleared");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    c_cmd: cover property ($rose(cmd_busy));
    c_special: cover property (special_cmd.valid);
    c_force: cover property (if_cfg.force_tx_zero);
endmodule
bind cpc_top cpc_top_asserts cpc_top_asserts_i (.*);

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import cpc_pkg::*;
    // design pins
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready = 0;
    cpc_lstat_t chan_line_status = '0;
    logic layer1_tx_in = 1'b0, layer1_tx_data, soft_reset, cmd_busy;
    cpc_if_cfg_t if_cfg;
    cpc_chan_cmd_t chan_cmd, seen_c;
    cpc_special_t special_cmd, seen_s;
    logic seen_r;
    int fail_count = 0, n_tests = 0, cycles = 0;
    cpc_top cpc_top_i (.*);
    // clock
    always #2.5 aclk = ~aclk;
    // remembers the last command pulses
    always @(negedge aclk) begin
        if (chan_cmd !== '0) seen_c = chan_cmd;
        if (special_cmd.valid === 1'b1) seen_s = special_cmd;
        if (soft_reset === 1'b1) seen_r = 1'b1;
    end
    // watchdog
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one write, bready held back up to st cycles
    task automatic wr(input logic [13:0] a, input logic [31:0] d,
                      input logic [3:0] s, input int st,
                      output logic [1:0] r);
        logic ha, hw, pa, pw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ha = pa && s_axi_awready;
            hw = pw && s_axi_wready;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            pa = pa && !ha;
            pw = pw && !hw;
        end
        repeat ($urandom_range(st)) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ha = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end while (!ha);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic h;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            h = s_axi_arready;
            @(posedge aclk);
        end while (!h);
        s_axi_arvalid <= 1'b0;
        repeat ($urandom_range(2)) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            h = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end while (!h);
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic [11:0] exp_strobe(input logic [7:0] c);
        if (c[7] || c[6] || c[2:1] == CH_RESERVED)
            return 12'h0;
        return 12'h1 << (3 * (3 - c[5:4]) + c[2:1]);
    endfunction
    function automatic cpc_if_cfg_t exp_cfg(input logic [15:0] m, k);
        return {m[15] && m[1:0] == 2'h3, m[14], m[13:12] == 2'h1,
                m[13:12] == 2'h2, m[13:12] == 2'h3, m[1:0], k};
    endfunction
    // issue a command, try to overwrite it while busy, then check
    task automatic docmd(input logic [7:0] c);
        logic [31:0] d;
        logic [1:0] r;
        seen_c = '0;
        seen_s = '0;
        seen_r = 1'b0;
        do begin
            rd(14'h2180, d, r);
        end while (d[8] !== 1'b0);
        wr(14'h2180, {16'h0, c, 8'h0}, 4'h2, 2, r);
        chk(cmd_busy, 1'b1);
        wr(14'h2180, {16'h0, c ^ 8'h30, 8'h0}, 4'h2, 0, r);
        chk(cmd_busy, 1'b1);
        while (cmd_busy !== 1'b0) @(negedge aclk);
        @(negedge aclk);
        chk(seen_c, exp_strobe(c));
        chk(seen_s, c[6] ? {1'b1, c[5:4]} : 3'h0);
        chk(seen_r, c[7]);
        rd(14'h2180, d, r);
        chk(d, {16'h0, c & 8'h76, 8'h0});
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] m, k;
        void'($urandom(32'h8f94ad10));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chan_line_status <= cpc_lstat_t'($urandom);
        rd(14'h22d0, d, r);
        chk(d, 32'h0);
        rd(14'h2184, d, r);
        chk({d, r}, {32'h0, RESP_DECERR});
        wr(14'h2184, 32'h1, 4'hf, 2, r);
        chk(r, RESP_DECERR);
        // line status ignores writes
        wr(14'h2230, 32'hff, 4'hf, 2, r);
        rd(14'h2230, d, r);
        chk(d, chan_line_status[0]);
        k = 16'($urandom);
        wr(14'h22c8, {16'h0, k}, 4'h3, 2, r);
        rd(14'h22c8, d, r);
        chk(d, k);
        m = 16'($urandom);
        wr(14'h2248, {16'h0, m}, 4'h3, 2, r);
        rd(14'h2248, d, r);
        chk(d, m);
        // every diag code, with and without the special interface
        for (int i = 0; i < 8; i++) begin
            m = 16'($urandom);
            m[13:12] = i[1:0];
            if (i > 3) m[1:0] = 2'h3;
            layer1_tx_in <= 1'($urandom);
            wr(14'h22d0, {16'h0, m}, 4'h3, 2, r);
            rd(14'h22d0, d, r);
            chk(d, m);
            chk(if_cfg, exp_cfg(m, k));
            chk(layer1_tx_data, layer1_tx_in && !(m[15] && &m[1:0]));
        end
        // reserved bit 3 written as zero
        for (int i = 0; i < 16; i++)
            docmd({2'b00, i[3:2], 1'b0, i[1:0], 1'b1});
        for (int i = 0; i < 4; i++)
            docmd({2'b01, i[1:0], 4'b0101});
        docmd(8'h81);
        rd(14'h22d0, d, r);
        chk(d, 32'h0);
        tally_and_finish();
    end
endmodule
